// ===== bench/counter_array_chk.sv
module counter_array_chk
    import counter_array_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       ce,
    input wire apb_req_t   apb_req,
    input wire apb_rsp_t   apb_rsp,
    input wire logic       debug_halt,
    input wire logic [4:0] cex_out,
    input wire logic       irq,
    input wire logic       wd_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_setup;
        apb_req.psel && !apb_req.penable && ce |=> apb_rsp.pready;
    endproperty
    a_setup: assert property (p_setup) else $error("no ready");
    property p_ready_pulse;
        apb_rsp.pready && ce |=> !apb_rsp.pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held");
    property p_err_ready;
        apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("bad error answer");
    property p_wd_pulse;
        wd_reset && ce |=> !wd_reset;
    endproperty
    a_wd_pulse: assert property (p_wd_pulse)
        else $error("watchdog pulse held");
    // Three cycles of margin for the registered watchdog pulse
    property p_halt_no_wd;
        (debug_halt && ce) [*3] |-> !wd_reset;
    endproperty
    a_halt_no_wd: assert property (p_halt_no_wd)
        else $error("watchdog fired in halt");
    property p_halt_out;
        (debug_halt && !apb_req.psel) [*4] |-> $stable(cex_out);
    endproperty
    a_halt_out: assert property (p_halt_out)
        else $error("outputs moved in halt");
    property p_ce_freeze;
        !ce |=> $stable(cex_out) && $stable(irq) && $stable(wd_reset);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("outputs moved with ce low");
    property p_ce_ready;
        !ce && !apb_rsp.pready |=> !apb_rsp.pready;
    endproperty
    a_ce_ready: assert property (p_ce_ready)
        else $error("ready with ce low");
    c_wd: cover property (wd_reset);
    c_irq: cover property (irq);
    c_err: cover property (apb_rsp.pslverr);
endmodule

// ===== bench/counter_array_tb.sv
`include "counter_array_regs.svh"
module counter_array_tb
    import counter_array_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, ce, debug_halt, timer0_ovf, irq, wd_reset;
    logic       ext_count_input, ext_osc;
    logic [4:0] cex_in, cex_out;
    apb_req_t   req;
    apb_rsp_t   rsp;
    int         error_cnt = 0;
    int         checks_done = 0;
    counter_array dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .apb_req(req),
        .apb_rsp(rsp), .debug_halt(debug_halt), .timer0_ovf(timer0_ovf),
        .ext_count_input(ext_count_input), .ext_osc(ext_osc),
        .cex_in(cex_in), .cex_out(cex_out), .irq(irq), .wd_reset(wd_reset));
    pin_model pin_u (.clk(clk), .ext_count_input(ext_count_input),
        .ext_osc(ext_osc), .cex_in(cex_in));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500us;
        error_cnt++;
        close_out();
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        r = rsp.prdata;
        e = rsp.pslverr;
        if (n >= 20) begin
            error_cnt++;
            close_out();
        end
        req <= '0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    task automatic t_defaults;
        logic [31:0] r;
        logic        e;
        rd(`CA_CTRL, r);
        chk("ctrl", r, 32'(`CA_CTRL_RST));
        rd(`CA_MOD_BASE + 8'h20, r);
        chk("mode4", r, 32'h7);
        rd(`CA_MOD_BASE + 8'h24, r);
        chk("cmp4", r, 32'(`CA_WD_CMP_RST));
        apb(1'b0, 8'h80, 32'h0, r, e);
        chk("slverr", {31'h0, e}, 32'h1);
        wr(`CA_MOD_BASE, 32'h7);
        rd(`CA_MOD_BASE, r);
        chk("mode0", r, 32'h0);
        for (int m = 0; m < 7; m++) begin
            wr(`CA_MOD_BASE + 8'h10, 32'(m));
            rd(`CA_MOD_BASE + 8'h10, r);
            chk("mode2", r, 32'(m));
        end
    endtask
    task automatic t_sources;
        logic [31:0] r;
        int          lo[6] = '{9, 29, 5, 7, 118, 1};
        int          hi[6] = '{11, 32, 5, 7, 128, 4};
        for (int s = 0; s < 6; s++) begin
            wr(`CA_CTRL, 32'(s << 1));
            wr(`CA_COUNT, 32'h0);
            wr(`CA_CTRL, 32'(s << 1 | 1));
            if (s == 2) begin
                repeat (5) begin
                    timer0_ovf <= 1'b1;
                    @(posedge clk);
                    timer0_ovf <= 1'b0;
                    @(posedge clk);
                end
            end else if (s == 3) begin
                pin_u.count_pulses(7);
            end else begin
                repeat (120) @(posedge clk);
            end
            wr(`CA_CTRL, 32'(s << 1));
            rd(`CA_COUNT, r);
            chk("ticks", 32'(r >= lo[s] && r <= hi[s]), 32'h1);
        end
    endtask
    task automatic t_halt;
        logic [31:0] a, b;
        wr(`CA_CTRL, 32'h9);
        debug_halt <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`CA_COUNT, a);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        repeat (20) @(posedge clk);
        rd(`CA_COUNT, b);
        chk("halted", b, a);
        debug_halt <= 1'b0;
        repeat (10) @(posedge clk);
        rd(`CA_COUNT, b);
        chk("resumed", 32'(b > a), 32'h1);
    endtask
    task automatic t_capture;
        logic [31:0] c0, r;
        int          n;
        wr(`CA_IEN, 32'h1);
        wr(`CA_MOD_BASE, 32'h9);
        rd(`CA_COUNT, c0);
        pin_u.cex_edge(0, 1'b1);
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk("irq", {31'h0, irq}, 32'h1);
        rd(`CA_MOD_BASE + `CA_CMP_OFS, r);
        chk("capture", 32'(r > c0 && r < c0 + 40), 32'h1);
        wr(`CA_CLEAR, 32'h1);
        wr(`CA_IEN, 32'h0);
        pin_u.cex_edge(0, 1'b0);
        repeat (4) @(posedge clk);
        pin_u.cex_edge(0, 1'b1);
        repeat (8) @(posedge clk);
        chk("masked", {31'h0, irq}, 32'h0);
        rd(`CA_STATUS, r);
        chk("flag", r & 32'h1, 32'h1);
        wr(`CA_CLEAR, 32'h1);
    endtask
    task automatic t_pwm;
        logic [31:0] cmp[4] = '{32'h80, 32'h80, 32'h1000, 32'h1000};
        logic [31:0] cnt[4] = '{32'h7F, 32'h80, 32'hFFF, 32'h1000};
        wr(`CA_CTRL, 32'h8);
        for (int i = 0; i < 4; i++) begin
            wr(`CA_MOD_BASE + 8'h08, (i < 2) ? 32'h4 : 32'h5);
            wr(`CA_MOD_BASE + 8'h0C, cmp[i]);
            wr(`CA_COUNT, cnt[i]);
            repeat (3) @(posedge clk);
            chk("pwm", {31'h0, cex_out[1]}, 32'(i % 2));
        end
    endtask
    task automatic t_hsout;
        logic [31:0] r;
        wr(`CA_CTRL, 32'h8);
        wr(`CA_MOD_BASE + 8'h18, 32'h3);
        wr(`CA_MOD_BASE + 8'h1C, 32'h10);
        wr(`CA_COUNT, 32'hE);
        wr(`CA_CTRL, 32'h9);
        repeat (10) @(posedge clk);
        wr(`CA_CTRL, 32'h8);
        chk("hs_out", {31'h0, cex_out[3]}, 32'h1);
        rd(`CA_STATUS, r);
        chk("hs_flag", (r >> 3) & 32'h1, 32'h1);
    endtask
    task automatic t_watchdog;
        logic [31:0] r;
        int          n;
        wr(`CA_CLEAR, 32'h3F);
        wr(`CA_COUNT, 32'hFFF0);
        wr(`CA_CTRL, 32'h9);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wd_reset !== 1'b1 && n < 40);
        chk("wd_reset", {31'h0, wd_reset}, 32'h1);
        rd(`CA_STATUS, r);
        chk("overflow", (r >> `CA_OVF_BIT) & 32'h1, 32'h1);
        rd(`CA_COUNT, r);
        chk("wrapped", 32'(r < 32'h100), 32'h1);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        debug_halt = 1'b0;
        timer0_ovf = 1'b0;
        req = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_defaults();
        t_sources();
        t_halt();
        t_capture();
        t_pwm();
        t_hsout();
        t_watchdog();
        close_out();
    end
endmodule
bind counter_array counter_array_chk chk_u (.clk(clk), .rst_n(rst_n),
    .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp), .debug_halt(debug_halt),
    .cex_out(cex_out), .irq(irq), .wd_reset(wd_reset));

// ===== bench/pin_model.sv
module pin_model (
    input  wire logic  clk,
    output logic       ext_count_input,
    output logic       ext_osc,
    output logic [4:0] cex_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_q = 2'h0;
    initial begin
        ext_count_input = 1'b0;
        ext_osc = 1'b0;
        cex_in = 5'h0;
    end
    // Oscillator runs free whatever the time base source is
    always @(posedge clk) begin
        div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
        if (div_q == 2'h2) ext_osc <= ~ext_osc;
    end
    // Pulses long enough for the two-flop synchroniser
    task automatic count_pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            ext_count_input <= 1'b1;
            repeat (4) @(posedge clk);
            ext_count_input <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic cex_edge(input int i, input logic v);
        @(posedge clk);
        cex_in[i] <= v;
    endtask
endmodule

// ===== logic/counter_array.sv
// Function
// - one 16-bit time base shared by five modules
// - time base source selectable among six inputs
// - modules 0 to 3 pick one of seven modes, module 4 one of eight
// - PWM available at 8 or 16 bits
// - module 4 can act as watchdog
// - module 4 is watchdog, enabled, after reset
// - module signals and count input reach pins
// - oscillator source counts edges synchronised to the system clock
// - counter array stalls while debug halts processor
`include "counter_array_regs.svh"

module counter_array
    import counter_array_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst_n,
    input  wire logic     ce,
    input  wire apb_req_t apb_req,
    output apb_rsp_t      apb_rsp,
    input  wire logic     debug_halt,
    input  wire logic     timer0_ovf,
    input  wire logic     ext_count_input,
    input  wire logic     ext_osc,
    input  wire logic [4:0] cex_in,
    output logic [4:0]    cex_out,
    output logic          irq,
    output logic          wd_reset
);

    logic [3:0]  ctrl_q;
    logic [15:0] count_q;
    logic [5:0]  status_q;
    logic [5:0]  ien_q;
    logic [5:0]  ev;
    logic [4:0]  mode_q [5];
    logic [15:0] cmp_q  [5];
    logic [4:0]  out_q;
    logic [4:0]  wd_hit;
    logic [3:0]  div12_q;
    logic [1:0]  div4_q;
    logic [2:0]  osc_div_q;
    logic [2:0]  eci_s_q;
    logic [2:0]  osc_s_q;
    logic        tick;
    logic        src_pulse;
    logic        irq_q;
    logic        wd_q;
    apb_rsp_t    rsp_q;
    logic [31:0] rd_data;
    logic        rd_err;
    logic        wr_en;
    logic [7:0]  addr;
    logic [7:0]  mod_ofs;
    logic [2:0]  mod_idx;
    logic        mod_hit;
    src_t        src;

    assign addr    = apb_req.paddr;
    assign src     = src_t'(ctrl_q[`CA_SRC_MSB:`CA_SRC_LSB]);
    assign mod_hit = addr >= `CA_MOD_BASE && addr <= `CA_MOD_LAST;
    assign mod_ofs = addr - `CA_MOD_BASE;
    assign mod_idx = mod_ofs[5:3];
    // Write lands only at the completing access edge
    assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite
                     && rsp_q.pready;

    // Pin inputs: two flops, third flop only for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eci_s_q <= 3'h0;
            osc_s_q <= 3'h0;
        end else if (ce) begin
            eci_s_q <= {eci_s_q[1:0], ext_count_input};
            osc_s_q <= {osc_s_q[1:0], ext_osc};
        end
    end

    // Prescalers stop with the counter in debug halt so debug steps stay in step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div12_q   <= 4'h0;
            div4_q    <= 2'h0;
            osc_div_q <= 3'h0;
        end else if (ce && !debug_halt) begin
            div12_q <= (div12_q == `CA_DIV12_MAX) ? 4'h0 : div12_q + 4'h1;
            div4_q  <= div4_q + 2'h1;
            // Counts oscillator edges seen through the clk-domain synchroniser
            if (osc_s_q[1] && !osc_s_q[2])
                osc_div_q <= osc_div_q + 3'h1;
        end
    end

    always_comb begin
        case (src)
            src_div12:     src_pulse = div12_q == `CA_DIV12_MAX;
            src_div4:      src_pulse = div4_q == `CA_DIV4_MAX;
            src_timer0:    src_pulse = timer0_ovf;
            src_ext_count: src_pulse = eci_s_q[1] && !eci_s_q[2];
            src_sysclk:    src_pulse = 1'b1;
            src_osc_div8:  src_pulse = osc_div_q == `CA_OSC8_MAX
                                       && osc_s_q[1] && !osc_s_q[2];
            default:       src_pulse = 1'b0;
        endcase
    end

    assign tick = src_pulse && ctrl_q[`CA_RUN_BIT] && !debug_halt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            ctrl_q <= `CA_CTRL_RST;
        else if (ce && wr_en && addr == `CA_CTRL)
            ctrl_q <= apb_req.pwdata[3:0];
    end

    // Shared time base
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            count_q <= 16'h0000;
        else if (ce) begin
            if (wr_en && addr == `CA_COUNT)
                count_q <= apb_req.pwdata[15:0];
            else if (tick)
                count_q <= count_q + 16'h0001;
        end
    end

    assign ev[`CA_OVF_BIT] = tick && count_q == 16'hFFFF;

    genvar i;
    for (i = 0; i < 5; i++) begin : g_mod
        mode_t m;
        logic  [2:0] cs_q;
        logic  edge_hit;
        logic  match;
        logic  match8;
        logic  wr_mode;
        logic  wr_cmp;

        assign m       = mode_t'(mode_q[i][`CA_MODE_MSB:0]);
        assign edge_hit = (mode_q[i][`CA_RISE_BIT] && cs_q[1] && !cs_q[2])
                       || (mode_q[i][`CA_FALL_BIT] && !cs_q[1] && cs_q[2]);
        assign match   = tick && count_q == cmp_q[i];
        assign match8  = tick && count_q[7:0] == cmp_q[i][7:0];
        assign wr_mode = wr_en && mod_hit && mod_idx == 3'(i)
                         && mod_ofs[2:0] == 3'h0;
        assign wr_cmp  = wr_en && mod_hit && mod_idx == 3'(i)
                         && mod_ofs[2:0] == `CA_CMP_OFS;

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n)
                cs_q <= 3'h0;
            else if (ce)
                cs_q <= {cs_q[1:0], cex_in[i]};
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n)
                mode_q[i] <= (i == 4) ? {2'b00, mode_watchdog}
                                      : 5'h00;
            else if (ce && wr_mode) begin
                // Watchdog only exists in module 4
                if (i != 4 && apb_req.pwdata[2:0] == mode_watchdog)
                    mode_q[i] <= 5'h00;
                else
                    mode_q[i] <= apb_req.pwdata[4:0];
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n)
                cmp_q[i] <= (i == 4) ? `CA_WD_CMP_RST : 16'h0000;
            else if (ce) begin
                if (wr_cmp)
                    cmp_q[i] <= apb_req.pwdata[15:0];
                else if (m == mode_capture && edge_hit)
                    cmp_q[i] <= count_q;
                else if (m == mode_freq_out && match8)
                    cmp_q[i][7:0] <= cmp_q[i][7:0] + cmp_q[i][15:8];
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n)
                out_q[i] <= 1'b0;
            else if (ce) begin
                case (m)
                    mode_hs_output: if (match) out_q[i] <= !out_q[i];
                    mode_freq_out:  if (match8) out_q[i] <= !out_q[i];
                    // Low while count is below compare
                    mode_pwm8:  out_q[i] <= count_q[7:0] >= cmp_q[i][7:0];
                    mode_pwm16: out_q[i] <= count_q >= cmp_q[i];
                    default:    out_q[i] <= 1'b0;
                endcase
            end
        end

        always_comb begin
            case (m)
                mode_capture:   ev[i] = edge_hit;
                mode_sw_timer,
                mode_hs_output,
                mode_pwm16:     ev[i] = match;
                mode_pwm8,
                mode_freq_out:  ev[i] = match8;
                default:        ev[i] = 1'b0;
            endcase
        end

        assign wd_hit[i] = m == mode_watchdog && match;
    end

    // Sticky flags: a new event beats a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            status_q <= 6'h00;
        else if (ce) begin
            if (wr_en && addr == `CA_CLEAR)
                status_q <= (status_q & ~apb_req.pwdata[5:0]) | ev;
            else
                status_q <= status_q | ev;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            ien_q <= 6'h00;
        else if (ce && wr_en && addr == `CA_IEN)
            ien_q <= apb_req.pwdata[5:0];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            wd_q  <= 1'b0;
        end else if (ce) begin
            irq_q <= |(status_q & ien_q);
            // Expiry: counter reaches module 4 compare
            wd_q  <= wd_hit[4];
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (mod_hit && mod_ofs[2:0] == 3'h0 && mod_idx < 3'h5)
            rd_data = {27'h0, mode_q[mod_idx]};
        else if (mod_hit && mod_ofs[2:0] == `CA_CMP_OFS && mod_idx < 3'h5)
            rd_data = {16'h0, cmp_q[mod_idx]};
        else begin
            case (addr)
                `CA_CTRL:   rd_data = {28'h0, ctrl_q};
                `CA_STATUS: rd_data = {26'h0, status_q};
                `CA_CLEAR:  rd_data = 32'h0000_0000;
                `CA_IEN:    rd_data = {26'h0, ien_q};
                `CA_COUNT:  rd_data = {16'h0, count_q};
                default:    rd_err  = 1'b1;
            endcase
        end
    end

    // One wait-free access phase: pready rises in the first access cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rsp_q <= '0;
        else if (ce) begin
            rsp_q.pready  <= apb_req.psel && !apb_req.penable
                             && !rsp_q.pready;
            rsp_q.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
            rsp_q.pslverr <= apb_req.psel && !apb_req.penable && rd_err;
        end
    end

    assign apb_rsp  = rsp_q;
    assign cex_out  = out_q;
    assign irq      = irq_q;
    assign wd_reset = wd_q;

endmodule

// ===== pkg/counter_array_pkg.sv
package counter_array_pkg;

    typedef enum logic [2:0] {
        mode_off,
        mode_capture,
        mode_sw_timer,
        mode_hs_output,
        mode_pwm8,
        mode_pwm16,
        mode_freq_out,
        mode_watchdog
    } mode_t;

    typedef enum logic [2:0] {
        src_div12,
        src_div4,
        src_timer0,
        src_ext_count,
        src_sysclk,
        src_osc_div8
    } src_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_t;

endpackage

// ===== pkg/counter_array_regs.svh
`ifndef COUNTER_ARRAY_REGS_SVH
`define COUNTER_ARRAY_REGS_SVH

// Byte offsets, 32-bit aligned words
`define CA_CTRL      8'h00
`define CA_STATUS    8'h04
`define CA_CLEAR     8'h08
`define CA_IEN       8'h0C
`define CA_COUNT     8'h10
`define CA_MOD_BASE  8'h20
`define CA_MOD_LAST  8'h47
`define CA_CMP_OFS   8'h04

// Control fields and reset value
`define CA_RUN_BIT   0
`define CA_SRC_LSB   1
`define CA_SRC_MSB   3
`define CA_CTRL_RST  4'h1

// Module mode fields
`define CA_MODE_MSB  2
`define CA_RISE_BIT  3
`define CA_FALL_BIT  4

// Status bits above the five module flags
`define CA_OVF_BIT   5
`define CA_NFLAGS    6

// Watchdog compare value at reset
`define CA_WD_CMP_RST 16'hFFFF

// Prescaler terminal counts
`define CA_DIV12_MAX 4'hB
`define CA_DIV4_MAX  2'h3
`define CA_OSC8_MAX  3'h7

`endif
